// *** core_glue.sv ***
// integration glue between the embedded processor core and the device
`timescale 1ns/1ps
`default_nettype none

module core_glue
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // oscillator pin
    input  wire logic                          main_oscillator_input,
    // peripheral interrupt sources
    input  wire logic [glue_pkg::IRQ_COUNT-1:0] irq_in,
    // core side
    input  wire glue_pkg::core_out_t           core_out,
    output var  glue_pkg::core_in_t            core_in,
    output logic [glue_pkg::IRQ_COUNT-1:0]     core_irq,
    output glue_pkg::calib_t                   core_calib,
    output logic                               tick_ref,
    // system reset
    output logic                               system_reset,
    // register port
    input  wire logic [glue_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [glue_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [glue_pkg::DATA_W-1:0]        reg_rdata
);

    // oscillator synchroniser and divider state
    logic                         osc_s1_q;     // first stage, read only by second
    logic                         osc_s2_q;     // settled oscillator level
    logic                         osc_s3_q;     // previous settled level for edge find
    logic [glue_pkg::DIV_W-1:0]   div_cnt_q;    // oscillator edge counter
    logic [glue_pkg::DIV_W-1:0]   div_cnt_d;
    logic                         tick_ref_q;   // divided reference
    logic                         tick_ref_d;
    logic                         osc_edge;     // rising edge of settled oscillator

    // system reset sequencer
    typedef enum logic {SEQ_IDLE, SEQ_HOLD} seq_state_t;
    seq_state_t                   seq_q;
    seq_state_t                   seq_d;
    logic [glue_pkg::HOLD_W-1:0]  hold_cnt_q;   // cycles left in the pulse
    logic [glue_pkg::HOLD_W-1:0]  hold_cnt_d;
    logic                         sys_rst_q;    // drives system_reset
    logic                         sys_rst_d;
    logic                         req_prev_q;   // last request level
    logic                         req_rise;     // request edge
    logic                         req_take;     // request honoured
    logic                         req_refuse;   // request refused in low-speed mode

    // register file state
    logic                         low_speed_q;  // software reports sub clock mode
    logic                         low_speed_d;
    logic                         refused_q;    // sticky: request seen in low-speed mode
    logic                         refused_d;
    logic                         req_reset_q;  // sticky: reset issued by request
    logic                         req_reset_d;
    logic [glue_pkg::DATA_W-1:0]  rdata_q;
    logic [glue_pkg::DATA_W-1:0]  rdata_d;

    // fixed core configuration, registered so outputs come from flops
    glue_pkg::core_in_t           core_in_q;
    glue_pkg::calib_t             calib_q;
    logic [glue_pkg::IRQ_COUNT-1:0] irq_q;

    // calibration word as the core and software see it
    function automatic glue_pkg::calib_t calib_word();
        glue_pkg::calib_t w;
        w                          = '0;
        w.no_reference_flag        = 1'b0;
        w.calibration_inexact_flag = 1'b0;
        w.value                    = glue_pkg::CALIB_VALUE;
        return w;
    endfunction

    // constant inputs to the core; event and exclusive paths stay dead
    function automatic glue_pkg::core_in_t core_cfg();
        glue_pkg::core_in_t c;
        c                      = '0;
        c.event_in             = 1'b0;
        c.exclusive_okay       = 1'b0;
        c.interrupt_line_count = glue_pkg::LINE_COUNT_VAL;
        c.priority_bits        = glue_pkg::PRIO_BITS_VAL;
        return c;
    endfunction

    // oscillator edge: settled level rose since last cycle
    assign osc_edge = osc_s2_q && !osc_s3_q;

    // divider next state
    always_comb
    begin
        div_cnt_d  = div_cnt_q;
        tick_ref_d = tick_ref_q;
        if (sys_rst_q)
        begin
            // system reset restarts the reference phase
            div_cnt_d  = '0;
            tick_ref_d = 1'b0;
        end
        else if (osc_edge)
        begin
            // one step per oscillator period, wraps every 32
            div_cnt_d  = div_cnt_q + 1'b1;
            tick_ref_d = div_cnt_d[glue_pkg::DIV_W-1];
        end
    end

    // synchroniser and divider registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_s1_q   <= 1'b0;
            osc_s2_q   <= 1'b0;
            osc_s3_q   <= 1'b0;
            div_cnt_q  <= '0;
            tick_ref_q <= 1'b0;
        end
        else
        begin
            osc_s1_q   <= main_oscillator_input;
            osc_s2_q   <= osc_s1_q;
            osc_s3_q   <= osc_s2_q;
            div_cnt_q  <= div_cnt_d;
            tick_ref_q <= tick_ref_d;
        end
    end

    // request decode; stuck state and deep sleep deliberately play no part
    assign req_rise   = core_out.system_reset_request && !req_prev_q;
    assign req_take   = req_rise && !low_speed_q && (seq_q == SEQ_IDLE);
    // a request in low-speed mode is unsafe, so it is refused and flagged
    assign req_refuse = req_rise && low_speed_q;

    // reset sequencer next state
    always_comb
    begin
        seq_d      = seq_q;
        hold_cnt_d = hold_cnt_q;
        sys_rst_d  = 1'b0;
        unique case (seq_q)
            SEQ_IDLE:
            begin
                if (req_take)
                begin
                    // start a fixed length system reset pulse
                    seq_d      = SEQ_HOLD;
                    hold_cnt_d = glue_pkg::HOLD_W'(glue_pkg::RST_HOLD_CYCLES - 1);
                    sys_rst_d  = 1'b1;
                end
            end
            SEQ_HOLD:
            begin
                if (hold_cnt_q == '0)
                begin
                    seq_d = SEQ_IDLE;
                end
                else
                begin
                    hold_cnt_d = hold_cnt_q - 1'b1;
                    sys_rst_d  = 1'b1;
                end
            end
        endcase
    end

    // reset sequencer registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seq_q      <= SEQ_IDLE;
            hold_cnt_q <= '0;
            sys_rst_q  <= 1'b0;
            req_prev_q <= 1'b0;
        end
        else
        begin
            seq_q      <= seq_d;
            hold_cnt_q <= hold_cnt_d;
            sys_rst_q  <= sys_rst_d;
            req_prev_q <= core_out.system_reset_request;
        end
    end

    // register file next state and read mux
    always_comb
    begin
        low_speed_d = low_speed_q;
        refused_d   = refused_q;
        req_reset_d = req_reset_q;
        rdata_d     = '0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                glue_pkg::OFF_CTRL:
                begin
                    low_speed_d = reg_wdata[glue_pkg::CTRL_LOW_SPEED_BIT];
                end
                glue_pkg::OFF_STATUS:
                begin
                    // write one to clear
                    if (reg_wdata[glue_pkg::ST_REFUSED_BIT])
                    begin
                        refused_d = 1'b0;
                    end
                    if (reg_wdata[glue_pkg::ST_REQ_RESET_BIT])
                    begin
                        req_reset_d = 1'b0;
                    end
                end
                // read-only and unmapped writes are dropped
                default:
                begin
                end
            endcase
        end
        // hardware set wins over a clear in the same cycle
        if (req_refuse)
        begin
            refused_d = 1'b1;
        end
        if (req_take)
        begin
            req_reset_d = 1'b1;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                glue_pkg::OFF_CTRL:
                begin
                    rdata_d[glue_pkg::CTRL_LOW_SPEED_BIT] = low_speed_q;
                end
                glue_pkg::OFF_STATUS:
                begin
                    rdata_d[glue_pkg::ST_REFUSED_BIT]    = refused_q;
                    rdata_d[glue_pkg::ST_REQ_RESET_BIT]  = req_reset_q;
                    // observation only, these levels steer nothing
                    rdata_d[glue_pkg::ST_STUCK_BIT]      = core_out.core_stuck_state;
                    rdata_d[glue_pkg::ST_DEEP_SLEEP_BIT] = core_out.deep_sleep_request;
                    rdata_d[glue_pkg::ST_TICK_LSB +: glue_pkg::DIV_W] = div_cnt_q;
                end
                glue_pkg::OFF_IC_TYPE:
                begin
                    rdata_d[4:0] = core_in_q.interrupt_line_count;
                end
                glue_pkg::OFF_CALIB:
                begin
                    rdata_d = calib_q;
                end
                glue_pkg::OFF_AUX_FLT:
                begin
                    rdata_d = glue_pkg::AUX_FAULT_VAL;
                end
                glue_pkg::OFF_CONFIG:
                begin
                    rdata_d[3:0] = core_in_q.priority_bits;
                end
                // unmapped reads return zero
                default:
                begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // register file, configuration and interrupt registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            low_speed_q <= glue_pkg::CTRL_RESET;
            refused_q   <= 1'b0;
            req_reset_q <= 1'b0;
            rdata_q     <= glue_pkg::RDATA_RESET;
            core_in_q   <= core_cfg();
            calib_q     <= calib_word();
            irq_q       <= '0;
        end
        else
        begin
            low_speed_q <= low_speed_d;
            refused_q   <= refused_d;
            req_reset_q <= req_reset_d;
            rdata_q     <= rdata_d;
            core_in_q   <= core_cfg();
            calib_q     <= calib_word();
            irq_q       <= irq_in;
        end
    end

    // outputs straight from flops
    assign core_in      = core_in_q;
    assign core_irq     = irq_q;
    assign core_calib   = calib_q;
    assign tick_ref     = tick_ref_q;
    assign system_reset = sys_rst_q;
    assign reg_rdata    = rdata_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    irq_pass_a: assert property (##1 core_irq == $past(irq_in))
        else $error("interrupt lines not passed to core");
    line_count_a: assert property (reg_rd && reg_addr == glue_pkg::OFF_IC_TYPE |=> reg_rdata == 32'h00000001)
        else $error("line count field wrong");
    prio_bits_a: assert property (reg_rd && reg_addr == glue_pkg::OFF_CONFIG |=> reg_rdata == 32'h00000003)
        else $error("priority bit count wrong");
    tick_phase_a: assert property ($changed(tick_ref) && !system_reset |-> div_cnt_q[3:0] == 4'h0)
        else $error("tick reference not divided by 32");
    calib_read_a: assert property (reg_rd && reg_addr == glue_pkg::OFF_CALIB |=> reg_rdata == 32'h000009C4)
        else $error("calibration read wrong");
    calib_flags_a: assert property (!core_calib.no_reference_flag && !core_calib.calibration_inexact_flag)
        else $error("calibration flags set");
    reset_pulse_a: assert property (req_take |=> system_reset [*8])
        else $error("reset request not honoured");
    slow_refuse_a: assert property (req_refuse |=> refused_q && !$rose(system_reset))
        else $error("low-speed request not refused");
    stuck_ignored_a: assert property (!req_take |=> !$rose(system_reset))
        else $error("reset raised without request");
    aux_zero_a: assert property (reg_rd && reg_addr == glue_pkg::OFF_AUX_FLT |=> reg_rdata == 32'h00000000)
        else $error("auxiliary fault status not zero");
    event_tied_a: assert property (!core_in.event_in)
        else $error("event input driven");
    excl_off_a: assert property (!core_in.exclusive_okay)
        else $error("exclusive access reported");
    div_clear_a: assert property (system_reset |=> div_cnt_q == '0 && !tick_ref)
        else $error("divider not cleared by system reset");

    reset_seen_c: cover property (req_take ##1 system_reset [*8]);
    refuse_seen_c: cover property (req_refuse);
    tick_wrap_c: cover property ($rose(tick_ref) ##[1:1000] $fell(tick_ref));

endmodule

`default_nettype wire

// *** glue_pkg.sv ***
// constants and carrier types for the processor core integration glue
package glue_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_IC_TYPE  = 8'h08;
    localparam logic [7:0] OFF_CALIB    = 8'h0C;
    localparam logic [7:0] OFF_AUX_FLT  = 8'h10;
    localparam logic [7:0] OFF_CONFIG   = 8'h14;

    // control and status field positions
    localparam int unsigned CTRL_LOW_SPEED_BIT = 0;
    localparam int unsigned ST_REFUSED_BIT     = 0;
    localparam int unsigned ST_REQ_RESET_BIT   = 1;
    localparam int unsigned ST_STUCK_BIT       = 2;
    localparam int unsigned ST_DEEP_SLEEP_BIT  = 3;
    localparam int unsigned ST_TICK_LSB        = 8;

    // core configuration
    localparam int unsigned IRQ_COUNT       = 50;
    localparam logic [4:0]  LINE_COUNT_VAL  = 5'h01;
    localparam logic [3:0]  PRIO_BITS_VAL   = 4'h3;
    localparam logic [23:0] CALIB_VALUE     = 24'h0009C4;
    localparam logic [31:0] AUX_FAULT_VAL   = 32'h00000000;

    // tick reference divider
    localparam int unsigned TICK_DIV   = 32;
    localparam int unsigned DIV_W      = $clog2(TICK_DIV);

    // system reset pulse length, least time rounded up
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned RST_HOLD_NS     = 400;
    localparam int unsigned RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W          = 5;

    // reset values
    localparam logic        CTRL_RESET     = 1'b0;
    localparam logic [31:0] RDATA_RESET    = 32'h00000000;

    // calibration word layout
    typedef struct packed {
        logic        no_reference_flag;
        logic        calibration_inexact_flag;
        logic [5:0]  reserved;
        logic [23:0] value;
    } calib_t;

    // signals leaving the core
    typedef struct packed {
        logic system_reset_request;
        logic core_stuck_state;
        logic event_out;
        logic deep_sleep_request;
        logic exclusive_request;
    } core_out_t;

    // signals entering the core
    typedef struct packed {
        logic       event_in;
        logic       exclusive_okay;
        logic [4:0] interrupt_line_count;
        logic [3:0] priority_bits;
    } core_in_t;

endpackage

// *** core_model.sv ***
// behavioural model of the processor core and its software as the glue sees them
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    // clock and resets
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                system_reset,
    // commands from the software scenario
    input  wire logic                want_reset,
    input  wire logic                stuck,
    input  wire logic                deep_sleep,
    input  wire logic                excl,
    // core pins
    input  wire glue_pkg::core_in_t  core_in,
    output var  glue_pkg::core_out_t core_out
);
    logic req_q; // reset request level held by the core
    logic req_d; // next request level

    // the request drops as soon as the system reset hits the core
    always_comb
    begin
        req_d = want_reset & ~system_reset;
    end

    // register the request like the core's own control bit
    always_ff @(posedge clk)
    begin
        req_q <= rst ? 1'b0 : req_d;
    end

    // software never issues send-event, so the event output stays low
    always_comb
    begin
        core_out.system_reset_request = req_q;
        core_out.core_stuck_state     = stuck;
        core_out.event_out            = 1'b0;
        core_out.deep_sleep_request   = deep_sleep;
        core_out.exclusive_request    = excl;
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking testbench for the processor core integration glue
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    logic                           osc = 1'b0;     // oscillator pin
    logic [glue_pkg::IRQ_COUNT-1:0] irq_in = '0;
    glue_pkg::core_out_t            core_out;
    glue_pkg::core_in_t             core_in;
    logic [glue_pkg::IRQ_COUNT-1:0] core_irq;
    glue_pkg::calib_t               core_calib;
    logic                           tick_ref;
    logic                           system_reset;
    logic [7:0]                     reg_addr = 8'h00;
    logic [31:0]                    reg_wdata = 32'h00000000;
    logic                           reg_wr = 1'b0;
    logic                           reg_rd = 1'b0;
    logic [31:0]                    reg_rdata;
    logic                           want_reset = 1'b0; // software commands
    logic                           stuck = 1'b0;
    logic                           deep_sleep = 1'b0;
    logic                           excl = 1'b0;
    int                             mismatches = 0;
    int                             n_checks = 0;
    int                             n;
    int                             seed_v;
    logic [31:0]                    r;
    logic [31:0]                    d;
    logic [7:0]                     addrs [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    // bench model of software-visible state
    int                             m_low_speed = 0;
    int                             m_refused = 0;
    int                             m_by_req = 0;
    logic [glue_pkg::IRQ_COUNT-1:0] irq_q [$];

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // oscillator of eight clock periods, so a tick half period is 128 cycles
    always
    begin
        repeat (4) @(posedge clk);
        osc <= ~osc;
    end

    core_glue DUT (.clk(clk), .rst(rst), .main_oscillator_input(osc), .irq_in(irq_in),
        .core_out(core_out), .core_in(core_in), .core_irq(core_irq), .core_calib(core_calib),
        .tick_ref(tick_ref), .system_reset(system_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    core_model core (.clk(clk), .rst(rst), .system_reset(system_reset), .want_reset(want_reset),
        .stuck(stuck), .deep_sleep(deep_sleep), .excl(excl), .core_in(core_in),
        .core_out(core_out));

    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected read data from the bench model
    function automatic logic [31:0] exp_read(input logic [7:0] a);
        case (a)
            8'h00: return {31'h00000000, m_low_speed[0]};
            8'h04: return {28'h0000000, deep_sleep, stuck, m_by_req[0], m_refused[0]};
            8'h08: return 32'h00000001;
            8'h0C: return 32'h000009C4;
            8'h14: return 32'h00000003;
            default: return 32'h00000000;
        endcase
    endfunction

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // count cycles until the tick reference shows a level, bounded
    task automatic wait_tick(input logic lvl, output int cnt);
        cnt = 0;
        while (tick_ref !== lvl && cnt < 1000)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    // software reset request; in low-speed mode no pulse may follow
    task automatic req_reset(input int lo);
        @(posedge clk);
        want_reset <= 1'b1;
        @(posedge clk);
        #1;
        check(system_reset, 0);
        @(posedge clk);
        #1;
        check(system_reset, (lo != 0) ? 0 : 1);
        n = 0;
        while (system_reset === 1'b1 && n < 40)
        begin
            @(posedge clk);
            want_reset <= 1'b0;
            #1;
            n++;
        end
        @(posedge clk);
        want_reset <= 1'b0;
        #1;
        check(n, (lo != 0) ? 0 : 16);
        if (lo != 0) m_refused = 1;
        else m_by_req = 1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        seed_v = $urandom(99657);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(core_in.event_in, 0);
        check(core_in.exclusive_okay, 0);
        check(core_in.interrupt_line_count, 5'h01);
        check(core_in.priority_bits, 4'h3);
        check(core_calib, 32'h000009C4);
        // random writes hit control, read-only and unmapped places; only the control write takes effect
        foreach (addrs[i])
        begin
            d = $urandom;
            wr(addrs[i], d);
            if (addrs[i] == 8'h00) m_low_speed = d[0];
            rd(addrs[i], r);
            check(r, exp_read(addrs[i]));
        end
        wr(8'h00, 32'h00000000);
        m_low_speed = 0;
        // back-to-back random interrupt levels pass one cycle later
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk);
            irq_q.push_back(glue_pkg::IRQ_COUNT'({$urandom, $urandom}));
            irq_in <= irq_q[$];
            #1;
            if (irq_q.size() > 1) check(core_irq, irq_q.pop_front());
        end
        // tick reference half periods
        wait_tick(1'b0, n);
        wait_tick(1'b1, n);
        wait_tick(1'b0, n);
        check(n, 128);
        wait_tick(1'b1, n);
        check(n, 128);
        // honoured reset request, divider cleared by it
        req_reset(0);
        check(tick_ref, 0);
        rd(8'h04, r);
        check(r[3:0], exp_read(8'h04) & 32'hF);
        // stuck, deep sleep and exclusive requests change nothing but the stuck and deep sleep status bits
        @(posedge clk);
        stuck <= 1'b1;
        deep_sleep <= 1'b1;
        excl <= 1'b1;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            check({system_reset, core_in.exclusive_okay, core_in.event_in}, 0);
        end
        rd(8'h04, r);
        check(r[3:0], exp_read(8'h04) & 32'hF);
        // only a reset leaves the stuck state: request still honoured
        req_reset(0);
        stuck <= 1'b0;
        deep_sleep <= 1'b0;
        excl <= 1'b0;
        wr(8'h04, 32'h00000003);
        m_by_req = 0;
        // low-speed mode refuses the request and flags it
        wr(8'h00, 32'h00000001);
        m_low_speed = 1;
        req_reset(1);
        rd(8'h04, r);
        check(r[3:0], exp_read(8'h04) & 32'hF);
        wr(8'h04, 32'h00000001);
        m_refused = 0;
        rd(8'h04, r);
        check(r[3:0], exp_read(8'h04) & 32'hF);
        rd(8'h00, r);
        check(r, exp_read(8'h00));
        print_verdict();
    end
endmodule
`default_nettype wire
